// file: rtl/dmacr_regs.sv
// DMA channel control and status register bank with AHB-Lite slave
// Contract
// R1: Writing 1 raises software request per channel
// R2: Bit n is channel n; extras ignored
// R3: Mask set write blocks peripheral requests; readable
// R4: Mask clear write unblocks peripheral requests
// R5: Enable set write enables channel; readable
// R6: Hardware clears enable on transfer completion
// R7: Enable clear write disables channel
// R8: Alternate set write selects alternate structure
// R9: Alternate clear write returns to primary
// R10: Priority set write raises channel priority
// R11: Priority clear write restores normal priority
// R12: Error flag bit 0, write 1 clears
// R13: Completion flags set per channel, write-1-clear
// R14: Completion interrupt enable set, readable
// R15: Completion interrupt enable clear write
// R16: Error interrupt enable set bit 0
// R17: Error interrupt enable clear bit 0
// R18: Interrupt only when flag and enable set
// R19: Completion and bus error set flags
// R20: Write-only registers read zero, no effect
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module dmacr_regs
	import dmacr_pkg::*;
#(
	parameter int NUM_CH = 32
)
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic [NUM_CH-1:0] engine_done,
	input  wire logic              engine_bus_error,
	output logic      [NUM_CH-1:0] soft_request_bits,
	output logic      [NUM_CH-1:0] request_mask_bits,
	output logic      [NUM_CH-1:0] channel_enable_bits,
	output logic      [NUM_CH-1:0] alternate_select_bits,
	output logic      [NUM_CH-1:0] priority_bits,
	output logic                   completion_irq,
	output logic                   error_irq
);

	// Address phase capture
	logic              wr_pend_reg;
	logic [11:0]       wr_addr_reg;
	logic [NUM_CH-1:0] done_flag_reg;
	logic [NUM_CH-1:0] done_ie_reg;
	logic              err_flag_reg;
	logic              err_ie_reg;
	logic              acc_valid;
	logic [NUM_CH-1:0] wdata_ch;
	logic [31:0]       rdata_next;
	logic              rd_take;
	// Write strobes, one per writable register, in the data phase
	logic              soft_req_wr;
	logic              rmask_set_wr;
	logic              rmask_clr_wr;
	logic              en_set_wr;
	logic              en_clr_wr;
	logic              alt_set_wr;
	logic              alt_clr_wr;
	logic              prio_set_wr;
	logic              prio_clr_wr;
	logic              err_flag_wr;
	logic              done_flag_wr;
	logic              done_ie_set_wr;
	logic              done_ie_clr_wr;
	logic              err_ie_set_wr;
	logic              err_ie_clr_wr;

	// Write strobe for one register in the data phase
	function automatic logic wr_hit(input logic pend, input logic [11:0] a, input logic [11:0] ofs);
		wr_hit = pend && (a == ofs);
	endfunction

	// Channel bits padded to a bus word
	function automatic logic [31:0] ch_word(input logic [NUM_CH-1:0] v);
		logic [31:0] w;
		w = 32'h00000000;
		w[NUM_CH-1:0] = v;
		ch_word = w;
	endfunction

	assign acc_valid = hsel && hready && (htrans == DMACR_HTRANS_NONSEQ || htrans == DMACR_HTRANS_SEQ);
	assign rd_take   = acc_valid && !hwrite;
	assign wdata_ch  = hwdata[NUM_CH-1:0]; // R2

	// Register decode of the pending write
	assign soft_req_wr    = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_SOFT_REQ_OFS);
	assign rmask_set_wr   = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_RMASK_SET_OFS);
	assign rmask_clr_wr   = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_RMASK_CLR_OFS);
	assign en_set_wr      = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_EN_SET_OFS);
	assign en_clr_wr      = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_EN_CLR_OFS);
	assign alt_set_wr     = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_ALT_SET_OFS);
	assign alt_clr_wr     = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_ALT_CLR_OFS);
	assign prio_set_wr    = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_PRIO_SET_OFS);
	assign prio_clr_wr    = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_PRIO_CLR_OFS);
	assign err_flag_wr    = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_ERR_FLAG_OFS);
	assign done_flag_wr   = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_DONE_FLAG_OFS);
	assign done_ie_set_wr = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_DONE_IE_SET_OFS);
	assign done_ie_clr_wr = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_DONE_IE_CLR_OFS);
	assign err_ie_set_wr  = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_ERR_IE_SET_OFS);
	assign err_ie_clr_wr  = wr_hit(wr_pend_reg, wr_addr_reg, DMACR_ERR_IE_CLR_OFS);

	// Write pending flag, set by a write address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= acc_valid && hwrite;
		end
	end

	// Word address of the transfer, held for its data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_addr_reg <= 12'h000;
		end
		else
		begin
			wr_addr_reg <= {haddr[11:2], 2'b00};
		end
	end

	// Ready never withdrawn; zero wait states
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
		end
		else
		begin
			hreadyout <= 1'b1;
		end
	end

	// Response always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hresp <= 1'b0;
		end
		else
		begin
			hresp <= 1'b0;
		end
	end

	// Software request pulse, one cycle per written 1
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			soft_request_bits <= '0;
		end
		else if (soft_req_wr)
		begin
			soft_request_bits <= wdata_ch; // R1
		end
		else
		begin
			soft_request_bits <= '0;
		end
	end

	// Peripheral request mask
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			request_mask_bits <= DMACR_RESET_VALUE[NUM_CH-1:0];
		end
		else if (rmask_set_wr)
		begin
			request_mask_bits <= request_mask_bits | wdata_ch; // R3
		end
		else if (rmask_clr_wr)
		begin
			request_mask_bits <= request_mask_bits & ~wdata_ch; // R4
		end
	end

	// Channel enable; a completion beats a set in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			channel_enable_bits <= DMACR_RESET_VALUE[NUM_CH-1:0];
		end
		else if (en_set_wr)
		begin
			channel_enable_bits <= (channel_enable_bits | wdata_ch) & ~engine_done; // R5 R6
		end
		else if (en_clr_wr)
		begin
			channel_enable_bits <= channel_enable_bits & ~wdata_ch & ~engine_done; // R7 R6
		end
		else
		begin
			channel_enable_bits <= channel_enable_bits & ~engine_done; // R6
		end
	end

	// Primary/alternate structure select
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			alternate_select_bits <= DMACR_RESET_VALUE[NUM_CH-1:0];
		end
		else if (alt_set_wr)
		begin
			alternate_select_bits <= alternate_select_bits | wdata_ch; // R8
		end
		else if (alt_clr_wr)
		begin
			alternate_select_bits <= alternate_select_bits & ~wdata_ch; // R9
		end
	end

	// Channel priority
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			priority_bits <= DMACR_RESET_VALUE[NUM_CH-1:0];
		end
		else if (prio_set_wr)
		begin
			priority_bits <= priority_bits | wdata_ch; // R10
		end
		else if (prio_clr_wr)
		begin
			priority_bits <= priority_bits & ~wdata_ch; // R11
		end
	end

	// Completion flags; a new completion wins over a clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_flag_reg <= DMACR_RESET_VALUE[NUM_CH-1:0];
		end
		else if (done_flag_wr)
		begin
			done_flag_reg <= (done_flag_reg & ~wdata_ch) | engine_done; // R13 R19
		end
		else
		begin
			done_flag_reg <= done_flag_reg | engine_done; // R19
		end
	end

	// Error flag; a new error wins over a clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			err_flag_reg <= DMACR_RESET_VALUE[DMACR_ERR_BIT_POS];
		end
		else if (engine_bus_error)
		begin
			err_flag_reg <= 1'b1; // R19
		end
		else if (err_flag_wr && hwdata[DMACR_ERR_BIT_POS])
		begin
			err_flag_reg <= 1'b0; // R12
		end
	end

	// Completion interrupt enables
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_ie_reg <= DMACR_RESET_VALUE[NUM_CH-1:0];
		end
		else if (done_ie_set_wr)
		begin
			done_ie_reg <= done_ie_reg | wdata_ch; // R14
		end
		else if (done_ie_clr_wr)
		begin
			done_ie_reg <= done_ie_reg & ~wdata_ch; // R15
		end
	end

	// Error interrupt enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			err_ie_reg <= DMACR_RESET_VALUE[DMACR_ERR_BIT_POS];
		end
		else if (err_ie_set_wr && hwdata[DMACR_ERR_BIT_POS])
		begin
			err_ie_reg <= 1'b1; // R16
		end
		else if (err_ie_clr_wr && hwdata[DMACR_ERR_BIT_POS])
		begin
			err_ie_reg <= 1'b0; // R17
		end
	end

	// Completion interrupt from any flagged and enabled channel
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			completion_irq <= 1'b0;
		end
		else
		begin
			completion_irq <= |(done_flag_reg & done_ie_reg); // R18
		end
	end

	// Error interrupt from flag and enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			error_irq <= 1'b0;
		end
		else
		begin
			error_irq <= err_flag_reg && err_ie_reg; // R18
		end
	end

	// Read mux, decoded in the address phase
	always_comb
	begin
		rdata_next = 32'h00000000;
		unique case ({haddr[11:2], 2'b00})
			DMACR_RMASK_SET_OFS:   rdata_next = ch_word(request_mask_bits);
			DMACR_EN_SET_OFS:      rdata_next = ch_word(channel_enable_bits);
			DMACR_ALT_SET_OFS:     rdata_next = ch_word(alternate_select_bits);
			DMACR_PRIO_SET_OFS:    rdata_next = ch_word(priority_bits);
			DMACR_ERR_FLAG_OFS:    rdata_next[DMACR_ERR_BIT_POS] = err_flag_reg;
			DMACR_DONE_FLAG_OFS:   rdata_next = ch_word(done_flag_reg);
			DMACR_DONE_IE_SET_OFS: rdata_next = ch_word(done_ie_reg);
			DMACR_ERR_IE_SET_OFS:  rdata_next[DMACR_ERR_BIT_POS] = err_ie_reg;
			default:               rdata_next = 32'h00000000; // R20
		endcase
	end

	// Read data register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
		end
		else if (rd_take)
		begin
			hrdata <= rdata_next;
		end
	end

endmodule

// file: rtl/dmacr_pkg.sv
// Package for the DMA channel control register bank
package dmacr_pkg;
	// Register byte offsets
	localparam logic [11:0] DMACR_SOFT_REQ_OFS      = 12'h000;
	localparam logic [11:0] DMACR_RMASK_SET_OFS     = 12'h004;
	localparam logic [11:0] DMACR_RMASK_CLR_OFS     = 12'h008;
	localparam logic [11:0] DMACR_EN_SET_OFS        = 12'h00C;
	localparam logic [11:0] DMACR_EN_CLR_OFS        = 12'h010;
	localparam logic [11:0] DMACR_ALT_SET_OFS       = 12'h014;
	localparam logic [11:0] DMACR_ALT_CLR_OFS       = 12'h018;
	localparam logic [11:0] DMACR_PRIO_SET_OFS      = 12'h01C;
	localparam logic [11:0] DMACR_PRIO_CLR_OFS      = 12'h020;
	localparam logic [11:0] DMACR_ERR_FLAG_OFS      = 12'h024;
	localparam logic [11:0] DMACR_DONE_FLAG_OFS     = 12'h028;
	localparam logic [11:0] DMACR_DONE_IE_SET_OFS   = 12'h02C;
	localparam logic [11:0] DMACR_DONE_IE_CLR_OFS   = 12'h030;
	localparam logic [11:0] DMACR_ERR_IE_SET_OFS    = 12'h034;
	localparam logic [11:0] DMACR_ERR_IE_CLR_OFS    = 12'h038;
	// Field position and reset value
	localparam int          DMACR_ERR_BIT_POS       = 0;
	localparam logic [31:0] DMACR_RESET_VALUE       = 32'h00000000;
	// AHB transfer type
	localparam logic [1:0]  DMACR_HTRANS_NONSEQ     = 2'h2;
	localparam logic [1:0]  DMACR_HTRANS_SEQ        = 2'h3;
endpackage

// file: dv/dmacr_regs_checker.sv
// Assertion checker for the DMA channel control register bank
`timescale 1ns/1ps
module dmacr_regs_checker
#(
	parameter int NUM_CH = 32
)
(
	input wire logic				hclk,
	input wire logic				hresetn,
	input wire logic				hsel,
	input wire logic [31:0]			haddr,
	input wire logic [1:0]			htrans,
	input wire logic				hwrite,
	input wire logic [31:0]			hwdata,
	input wire logic				hready,
	input wire logic [31:0]			hrdata,
	input wire logic [NUM_CH-1:0]	engine_done,
	input wire logic [NUM_CH-1:0]	soft_request_bits,
	input wire logic [NUM_CH-1:0]	request_mask_bits,
	input wire logic [NUM_CH-1:0]	channel_enable_bits,
	input wire logic [NUM_CH-1:0]	priority_bits
);
	logic [13:0]		ph_q;
	wire logic			tk = hsel & hready & htrans[1];
	wire logic [NUM_CH-1:0]	wd = hwdata[NUM_CH-1:0];
	// Write flag, read flag and offset of the transfer in its data phase
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ph_q <= '0;
		else
			ph_q <= {tk & hwrite, tk & !hwrite, haddr[11:0]};
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Data phase of a write or a read at one offset
	sequence wr_at(logic [11:0] o);
		ph_q[13] && ph_q[11:0] == o;
	endsequence
	sequence rd_at(logic [11:0] o);
		ph_q[12] && ph_q[11:0] == o;
	endsequence
	// Effects seen the cycle after a data phase; read data checked in the data phase
	soft_pulse_a: assert property (1'b1 |=> soft_request_bits == $past(ph_q == 14'h2000 ? wd : '0))
		else $error("soft request wrong");
	mask_set_a: assert property (wr_at(12'h004) |=> request_mask_bits == $past(request_mask_bits | wd))
		else $error("mask set wrong");
	mask_clr_a: assert property (wr_at(12'h008) |=> request_mask_bits == $past(request_mask_bits & ~wd))
		else $error("mask clear wrong");
	en_clr_a: assert property (wr_at(12'h010) |=>
		channel_enable_bits == $past(channel_enable_bits & ~(wd | engine_done)))
		else $error("enable clear wrong");
	en_done_a: assert property (|engine_done |=> (channel_enable_bits & $past(engine_done)) == '0)
		else $error("enable not cleared");
	prio_set_a: assert property (wr_at(12'h01C) |=> priority_bits == $past(priority_bits | wd))
		else $error("priority set wrong");
	wo_read_a: assert property (ph_q[12] && (ph_q[11:0] inside {12'h000, 12'h008}) |-> hrdata == '0)
		else $error("write-only read not zero");
	mask_read_a: assert property (rd_at(12'h004) |-> hrdata == 32'($past(request_mask_bits)))
		else $error("mask read wrong");
endmodule
bind dmacr_regs dmacr_regs_checker #(.NUM_CH(NUM_CH)) u_chk (.*);

// file: dv/dmacr_ahb_master.sv
// AHB-Lite master model issuing single word transfers
`timescale 1ns/1ps
module dmacr_ahb_master
	import dmacr_pkg::*;
(
	input wire logic		hclk,
	input wire logic		hready,
	input wire logic [31:0]	hrdata,
	output logic			hsel = 1'b0,
	output logic [31:0]		haddr = 32'h0,
	output logic [1:0]		htrans = 2'h0,
	output logic			hwrite = 1'b0,
	output logic [2:0]		hsize = 3'h2,
	output logic [31:0]		hwdata = 32'h0,
	output logic			hang = 1'b0
);
	// Bounded wait for hready at a rising edge
	task automatic wait_rdy();
		for (int n = 0; n < 64; n++)
		begin
			@(posedge hclk);
			if (hready === 1'b1)
				return;
		end
		hang <= 1'b1;
	endtask
	// Address phase, then data phase; unused write data toggles
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= DMACR_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		wait_rdy();
		q = hrdata;
	endtask
endmodule

// file: dv/dma_channel_control_regs_test.sv
// Testbench for the DMA channel control register bank
`timescale 1ns/1ps
module dma_channel_control_regs_test;
	typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} dmacr_row_s;
	logic			hclk = 1'b0, hresetn = 1'b0, engine_bus_error = 1'b0;
	logic			hsel, hwrite, hreadyout, hresp, hang, completion_irq, error_irq;
	logic [7:0]		engine_done = 8'h0, soft_request_bits, request_mask_bits, channel_enable_bits;
	logic [7:0]		alternate_select_bits, priority_bits;
	logic [31:0]	haddr, hwdata, hrdata, q;
	logic [1:0]		htrans;
	logic [2:0]		hsize;
	wire logic		hready = hreadyout;
	int				bad_count = 0, num_checks = 0;
	// Write offset and data, then read offset and expected value
	dmacr_row_s rows [15] = '{
		'{12'h004, 32'hFFFFFF0F, 12'h004, 32'h0F}, '{12'h008, 32'h3, 12'h004, 32'h0C},
		'{12'h004, 32'h0, 12'h004, 32'h0C}, '{12'h00C, 32'hA5, 12'h00C, 32'hA5},
		'{12'h010, 32'h5, 12'h00C, 32'hA0}, '{12'h014, 32'hFF, 12'h014, 32'hFF},
		'{12'h018, 32'hF, 12'h014, 32'hF0}, '{12'h01C, 32'h81, 12'h01C, 32'h81},
		'{12'h020, 32'h1, 12'h01C, 32'h80}, '{12'h02C, 32'h33, 12'h02C, 32'h33},
		'{12'h030, 32'h11, 12'h02C, 32'h22}, '{12'h034, 32'hFFFFFFFF, 12'h034, 32'h1},
		'{12'h038, 32'h1, 12'h034, 32'h0}, '{12'h008, 32'hFF, 12'h008, 32'h0},
		'{12'h03C, 32'hFFFFFFFF, 12'h03C, 32'h0}};
	dmacr_regs #(.NUM_CH(8)) dut (.*);
	dmacr_ahb_master bus (.*);
	always #12.5 hclk = ~hclk;
	// Compare, bus access and engine event helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic pulse(input logic [7:0] d, input logic e);
		@(posedge hclk);
		engine_done <= d;
		engine_bus_error <= e;
		@(posedge hclk);
		engine_done <= 8'h0;
		engine_bus_error <= 1'b0;
	endtask
	task automatic conclude();
		$display("checks=%0d bad=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// A bus wait that ran out ends the run
	always @(posedge hang)
	begin
		bad_count++;
		conclude();
	end
	// Table, second reset, then flag and interrupt cases
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra, rows[i].ex);
		end
		chk(32'(request_mask_bits), 32'h00);
		chk(32'(channel_enable_bits), 32'hA0);
		chk(32'(alternate_select_bits), 32'hF0);
		chk(32'(priority_bits), 32'h80);
		chk({30'h0, hresp, hreadyout}, 32'h1);
		$display("table done");
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 4; a < 56; a += 8)
			rd(12'(a), 32'h0);
		$display("reset done");
		wr(12'h00C, 32'h3);
		wr(12'h02C, 32'h1);
		pulse(8'h02, 1'b0);
		rd(12'h028, 32'h2);
		rd(12'h00C, 32'h1);
		chk(32'(completion_irq), 32'h0);
		pulse(8'h01, 1'b0);
		rd(12'h00C, 32'h0);
		chk(32'(completion_irq), 32'h1);
		wr(12'h028, 32'h1);
		rd(12'h028, 32'h2);
		chk(32'(completion_irq), 32'h0);
		pulse(8'h00, 1'b1);
		rd(12'h024, 32'h1);
		chk(32'(error_irq), 32'h0);
		wr(12'h034, 32'h1);
		wr(12'h024, 32'h0);
		rd(12'h024, 32'h1);
		chk(32'(error_irq), 32'h1);
		wr(12'h024, 32'h1);
		rd(12'h024, 32'h0);
		chk(32'(error_irq), 32'h0);
		wr(12'h000, 32'h181);
		#1 chk(32'(soft_request_bits), 32'h81);
		@(posedge hclk);
		#1 chk(32'(soft_request_bits), 32'h00);
		@(posedge hclk);
		rd(12'h000, 32'h0);
		$display("events done");
		conclude();
	end
endmodule
